// ---- design/cgc_regs.sv ----
// The implementer's own choices: the register addresses and the Wishbone register port.
`include "cgc_cfg.svh"
`default_nettype none
module cgc_regs (
    input  wire logic               clock,
    input  wire logic               reset,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [3:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    output logic                    wb_err_o,
    input  wire logic               ext_ref_stable_in,
    input  wire logic               lock_loss_in,
    input  wire logic               clock_loss_in,
    input  wire logic               off_mode,
    input  wire logic               osc_enable_in,
    output var cgc_pkg::cgc_ctrl_s  ctrl,
    output logic [1:0]              mode_report,
    output logic                    osc_run_in_off,
    output logic                    lock_loss_sticky,
    output logic                    irq_request,
    output logic                    reset_request
);
    // -----------------------------------------------------------------
    // Bus decode
    // -----------------------------------------------------------------
    wire logic access    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire logic hit_one   = wb_adr_i == `CGC_ADDR_CTRL_ONE;
    wire logic hit_two   = wb_adr_i == `CGC_ADDR_CTRL_TWO;
    wire logic hit_stat  = wb_adr_i == `CGC_ADDR_STATUS;
    wire logic mapped    = hit_one | hit_two | hit_stat;
    wire logic wr_one    = access & wb_we_i & hit_one & wb_sel_i[0];
    wire logic wr_two    = access & wb_we_i & hit_two & wb_sel_i[0];
    wire logic wr_stat   = access & wb_we_i & hit_stat & wb_sel_i[0];
    wire logic [7:0] wd  = wb_dat_i[7:0];

    // -----------------------------------------------------------------
    // Stored fields
    // -----------------------------------------------------------------
    logic       gain_reg, band_reg, reft_reg, oscoff_reg, lossoff_reg;
    logic       lockrst_reg, clkrst_reg;
    logic [1:0] mode_reg;
    logic [2:0] mul_reg, div_reg;
    logic       gain_done_reg, band_done_reg, reft_done_reg, mode_done_reg;
    logic       ext_lock_reg;
    logic [2:0] pend_reg;
    logic [7:0] pend_cnt_reg;
    cgc_pkg::cgc_apply_s applied_reg;
    logic       stab_meta_reg, stab_reg, lol_meta_reg, lol_sync_reg, lol_prev_reg;
    logic       loc_meta_reg, loc_sync_reg, lls_reg;

    wire logic mode_ok  = ~pend_reg[2] & ~(ext_lock_reg & wd[`CGC_BIT_MODE_HI]);
    wire logic mul_ok   = ~pend_reg[1];
    wire logic div_ok   = ~pend_reg[0];
    wire logic [1:0] new_mode = wd[`CGC_BIT_MODE_HI:`CGC_BIT_MODE_LO];
    wire logic [2:0] new_mul  = wd[`CGC_BIT_MUL_HI:`CGC_BIT_MUL_LO];
    wire logic [2:0] new_div  = wd[`CGC_BIT_DIV_HI:`CGC_BIT_DIV_LO];
    wire logic mode_chg = wr_one & mode_ok & (new_mode != mode_reg);
    wire logic mul_chg  = wr_two & mul_ok & (new_mul != mul_reg);
    wire logic div_chg  = wr_two & div_ok & (new_div != div_reg);
    wire logic apply_now = (pend_reg != 3'h0) && (pend_cnt_reg == 8'h00);

    always_ff @(posedge clock) begin
        if (reset) begin
            {gain_reg, band_reg, reft_reg, oscoff_reg, lossoff_reg} <= 5'h00;
            {gain_done_reg, band_done_reg, reft_done_reg, mode_done_reg} <= 4'h0;
            ext_lock_reg <= 1'b0;
            mode_reg     <= 2'h0;
        end else if (wr_one) begin
            if (!gain_done_reg) gain_reg <= wd[`CGC_BIT_GAIN];
            if (!band_done_reg) band_reg <= wd[`CGC_BIT_BAND];
            if (!reft_done_reg) reft_reg <= wd[`CGC_BIT_REFTYPE];
            {gain_done_reg, band_done_reg, reft_done_reg, mode_done_reg} <= 4'hF;
            if (!mode_done_reg) ext_lock_reg <= ~wd[`CGC_BIT_MODE_HI];
            if (mode_ok) mode_reg <= new_mode;
            oscoff_reg  <= wd[`CGC_BIT_OSC_OFF];
            lossoff_reg <= wd[`CGC_BIT_LOSS_OFF];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            {lockrst_reg, clkrst_reg} <= 2'h0;
            mul_reg <= 3'h0;
            div_reg <= 3'h0;
        end else if (wr_two) begin
            lockrst_reg <= wd[`CGC_BIT_LOCK_RST];
            clkrst_reg  <= wd[`CGC_BIT_CLK_RST];
            if (mul_ok) mul_reg <= new_mul;
            if (div_ok) div_reg <= new_div;
        end
    end

    // -----------------------------------------------------------------
    // Apply pending changes after the domain-crossing delay
    // -----------------------------------------------------------------
    // Bypass change waits for a stable reference, so the source is never switched to a dead clock
    wire logic mode_ready = (mode_reg != cgc_pkg::CGC_BYPASS_EXTERNAL) | stab_reg;

    always_ff @(posedge clock) begin
        if (reset) begin
            pend_reg     <= 3'h0;
            pend_cnt_reg <= 8'h00;
            applied_reg  <= '0;
        end else if (mode_chg | mul_chg | div_chg) begin
            pend_reg     <= pend_reg | {mode_chg, mul_chg, div_chg};
            pend_cnt_reg <= 8'(`CGC_APPLY_CYCLES);
        end else if (pend_cnt_reg != 8'h00) begin
            pend_cnt_reg <= pend_cnt_reg - 8'h01;
        end else if (apply_now) begin
            if (pend_reg[1]) applied_reg.mult <= mul_reg;
            if (pend_reg[0]) applied_reg.div  <= div_reg;
            if (pend_reg[2] && mode_ready) applied_reg.mode <= mode_reg;
            pend_reg <= {pend_reg[2] & ~mode_ready, 2'b00};
        end
    end

    // -----------------------------------------------------------------
    // Status inputs: pins from other domains, two flops each
    // -----------------------------------------------------------------
    wire logic lol_rise = lol_sync_reg & ~lol_prev_reg;
    always_ff @(posedge clock) begin
        if (reset) begin
            {stab_meta_reg, stab_reg, lol_meta_reg, lol_sync_reg, lol_prev_reg} <= 5'h00;
            {loc_meta_reg, loc_sync_reg, lls_reg} <= 3'h0;
        end else begin
            stab_meta_reg <= ext_ref_stable_in;
            stab_reg      <= stab_meta_reg;
            lol_meta_reg  <= lock_loss_in;
            lol_sync_reg  <= lol_meta_reg;
            lol_prev_reg  <= lol_sync_reg;
            loc_meta_reg  <= clock_loss_in;
            loc_sync_reg  <= loc_meta_reg;
            // Set wins over a clear arriving in the same cycle
            if (lol_rise) lls_reg <= 1'b1;
            else if (wr_stat && wd[`CGC_BIT_LOL_CLR]) lls_reg <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Derived controls
    // -----------------------------------------------------------------
    wire logic ext_mode   = applied_reg.mode[1];
    wire logic loss_event = loc_sync_reg & ~lossoff_reg;
    wire logic [7:0] status = {applied_reg.mode, reft_reg, lls_reg, 2'b00, stab_reg, 1'b0};

    assign mode_report      = applied_reg.mode;
    assign lock_loss_sticky = lls_reg;
    assign irq_request   = (lls_reg & ~lockrst_reg) | (loss_event & ~clkrst_reg);
    assign reset_request = (lls_reg & lockrst_reg) | (loss_event & clkrst_reg);
    assign osc_run_in_off = off_mode & reft_reg &
        ((gain_reg & band_reg) ? (mode_reg[1] & osc_enable_in & ~mode_reg[0]) :
         oscoff_reg ? mode_reg[1] :
         (osc_enable_in & (mode_reg == cgc_pkg::CGC_BYPASS_EXTERNAL)));

    always_comb begin
        ctrl.gain            = gain_reg;
        ctrl.band            = band_reg;
        ctrl.ref_crystal     = reft_reg;
        ctrl.osc_keep_in_off = osc_run_in_off;
        ctrl.loss_detect_on  = ~lossoff_reg;
        ctrl.prescale        = (ext_mode & band_reg) ? `CGC_PRESCALE_HIGH : `CGC_PRESCALE_LOW;
        ctrl.mult_factor     = `CGC_MUL_BASE + {1'b0, applied_reg.mult, 1'b0};
        ctrl.div_factor      = 8'h01 << applied_reg.div;
    end

    // -----------------------------------------------------------------
    // Bus answer: one registered ack, a cycle after the strobe; err on unmapped address
    // -----------------------------------------------------------------
    wire logic [7:0] rd_sel = hit_one ? {gain_reg, band_reg, reft_reg, mode_reg, oscoff_reg, lossoff_reg, 1'b0} :
                              hit_two ? {lockrst_reg, mul_reg, clkrst_reg, div_reg} : status;
    always_ff @(posedge clock) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= access & mapped;
            wb_err_o <= access & ~mapped;
            wb_dat_o <= {24'h00_0000, (access & mapped) ? rd_sel : 8'h00};
        end
    end
endmodule
`default_nettype wire

// ---- design/cgc_cfg.svh ----
// Functional notes
// - Gain bit 7 of control one takes first write only; 0 low power, 1 high gain.
// - Band bit 0 gives low range and prescale 64; 1 gives high range, prescale 1.
// - Band bit 6 takes first write after reset only.
// - Band setting acts only in bypassed-external or engaged-external modes.
// - Reference type bit 5 is write-once; 0 external clock, 1 crystal oscillator.
// - Mode field bits 4:3 selects self-clocked, loop internal, bypass external, loop external.
// - Bypass external request keeps present source until reference stable reads 1.
// - Entering off mode leaves the mode field unchanged.
// - Mode writes are ignored while an earlier mode write is pending.
// - First mode write with upper bit 0 blocks later upper-bit-1 writes until reset.
// - Off-mode oscillator bit decides whether oscillator runs in off mode.
// - Off-mode oscillator bit has no effect when gain and band bits are both 1.
// - Clock-loss disable bit 1: 0 detection enabled, 1 disabled.
// - Sticky lock loss gives interrupt when bit 7 of control two is 0, reset when 1.
// - Multiplier codes 000 to 111 give factors 4 to 18 in steps of two.
// - Multiplier writes in bits 6:4 are ignored while an earlier one is pending.
// - Clock loss gives interrupt when bit 3 is 0, reset request when 1.
// - Output divider divides by two to the power of the code, 1 to 128.
// - Divider writes in bits 2:0 are ignored while an earlier one is pending.
// - Mode report shows active mode, updated only after synchronisation.
// - Reference stable flag reads 1 only when reference meets minimum frequency.
// - Lock loss flag is sticky until cleared.
`ifndef CGC_CFG_SVH
`define CGC_CFG_SVH
`define CGC_ADDR_CTRL_ONE   4'h0
`define CGC_ADDR_CTRL_TWO   4'h4
`define CGC_ADDR_STATUS     4'h8
`define CGC_BIT_GAIN        7
`define CGC_BIT_BAND        6
`define CGC_BIT_REFTYPE     5
`define CGC_BIT_MODE_HI     4
`define CGC_BIT_MODE_LO     3
`define CGC_BIT_OSC_OFF     2
`define CGC_BIT_LOSS_OFF    1
`define CGC_BIT_LOCK_RST    7
`define CGC_BIT_MUL_HI      6
`define CGC_BIT_MUL_LO      4
`define CGC_BIT_CLK_RST     3
`define CGC_BIT_DIV_HI      2
`define CGC_BIT_DIV_LO      0
`define CGC_BIT_LOL_CLR     4
`define CGC_RESET_ONE       8'h00
`define CGC_RESET_TWO       8'h00
`define CGC_PRESCALE_LOW    7'h40
`define CGC_PRESCALE_HIGH   7'h01
`define CGC_MUL_BASE        5'h04
`define CGC_APPLY_NS        24
`define CGC_CLOCK_MHZ       125
`define CGC_APPLY_CYCLES    ((`CGC_APPLY_NS * `CGC_CLOCK_MHZ + 999) / 1000)
`endif

// ---- design/cgc_pkg.sv ----
`default_nettype none
package cgc_pkg;
    typedef enum logic [1:0] {
        CGC_SELF_CLOCKED,
        CGC_LOOP_INTERNAL,
        CGC_BYPASS_EXTERNAL,
        CGC_LOOP_EXTERNAL
    } cgc_mode_e;
    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] mult;
        logic [2:0] div;
    } cgc_apply_s;
    typedef struct packed {
        logic       gain;
        logic       band;
        logic       ref_crystal;
        logic       osc_keep_in_off;
        logic       loss_detect_on;
        logic [6:0] prescale;
        logic [4:0] mult_factor;
        logic [7:0] div_factor;
    } cgc_ctrl_s;
endpackage
`default_nettype wire

// ---- test/cgc_regs_props.sv ----
`default_nettype none
module cgc_regs_props (
    input wire logic               clock,
    input wire logic               reset,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [3:0]         wb_adr_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    input wire logic               wb_err_o,
    input wire logic               ext_ref_stable_in,
    input wire logic               lock_loss_in,
    input wire logic               clock_loss_in,
    input wire logic               off_mode,
    input wire logic               osc_enable_in,
    input wire cgc_pkg::cgc_ctrl_s ctrl,
    input wire logic [1:0]         mode_report,
    input wire logic               osc_run_in_off,
    input wire logic               lock_loss_sticky,
    input wire logic               irq_request,
    input wire logic               reset_request
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire mapped = wb_adr_i == 4'h0 || wb_adr_i == 4'h4 || wb_adr_i == 4'h8;
    wire clear = take && wb_we_i && wb_adr_i == 4'h8 && wb_dat_i[4];
    a_ack_answer: assert property (take && mapped |=> wb_ack_o && !wb_err_o) else $error("no ack");
    a_err_unmapped: assert property (take && !mapped |=> wb_err_o && !wb_ack_o) else $error("no err");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
    a_prescale_band: assert property (ctrl.prescale == ((ctrl.band && mode_report[1]) ? 7'h01 : 7'h40))
        else $error("bad prescale");
    a_mult_range: assert property (!ctrl.mult_factor[0] && ctrl.mult_factor >= 5'h04
        && ctrl.mult_factor <= 5'h12) else $error("bad multiplier");
    a_div_power: assert property ($onehot(ctrl.div_factor)) else $error("bad divider");
    a_sticky_hold: assert property (lock_loss_sticky && !clear |=> lock_loss_sticky)
        else $error("sticky lost");
    a_lock_request: assert property (lock_loss_sticky |-> irq_request || reset_request)
        else $error("no lock request");
    a_loss_request: assert property (ctrl.loss_detect_on && $past(clock_loss_in, 2) && !$past(reset)
        && !$past(reset, 2) |-> irq_request || reset_request) else $error("no loss request");
    a_bypass_wait: assert property ($changed(mode_report) && mode_report == 2'h2
        |-> $past(ext_ref_stable_in, 2) || $past(ext_ref_stable_in, 3) || $past(ext_ref_stable_in, 4))
        else $error("bypass too early");
    c_write: cover property (take && wb_we_i);
    c_reset_req: cover property (lock_loss_sticky && reset_request);
    c_bypass: cover property ($changed(mode_report) && mode_report == 2'h2);
endmodule
bind cgc_regs cgc_regs_props i_props (.clock, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .ext_ref_stable_in, .lock_loss_in, .clock_loss_in, .off_mode,
    .osc_enable_in, .ctrl, .mode_report, .osc_run_in_off, .lock_loss_sticky, .irq_request, .reset_request);
`default_nettype wire

// ---- test/cgc_regs_tb.sv ----
`default_nettype none
module cgc_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clock = 1'h0;
    logic               reset = 1'h1;
    logic               wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [3:0]         wb_adr_i = 4'h0, wb_sel_i = 4'h1;
    logic [31:0]        wb_dat_i = 32'h0, wb_dat_o;
    logic               ext_ref_stable_in = 1'h0, lock_loss_in = 1'h0, clock_loss_in = 1'h0;
    logic               off_mode = 1'h0, osc_enable_in = 1'h0;
    logic               wb_ack_o, wb_err_o, osc_run_in_off, lock_loss_sticky, irq_request, reset_request;
    logic [1:0]         mode_report;
    cgc_pkg::cgc_ctrl_s ctrl;
    int                 error_cnt = 0, compares = 0, cycles = 0;
    always #4 clock = ~clock;
    cgc_regs i_dut (.clock, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .wb_err_o, .ext_ref_stable_in, .lock_loss_in, .clock_loss_in, .off_mode,
        .osc_enable_in, .ctrl, .mode_report, .osc_run_in_off, .lock_loss_sticky, .irq_request, .reset_request);
    task automatic end_of_test;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Generous ceiling: the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Classic cycle; answer is waited for, never assumed
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q,
        output logic e);
        @(posedge clock);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do @(posedge clock); while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1);
        q = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic        e;
        logic [31:0] v;
        int          exp_q[$];
        void'($urandom(32'h3A88A05C));
        tick(10);
        reset <= 1'h0;
        wb(1'h1, 4'h0, 8'hF0, q, e);
        wb(1'h1, 4'h0, 8'hF8, q, e);
        tick(10);
        chk(mode_report, 32'h0);
        ext_ref_stable_in <= 1'h1;
        tick(10);
        chk(mode_report, 32'h2);
        wb(1'h1, 4'h0, 8'h1C, q, e);
        off_mode <= 1'h1;
        tick(8);
        chk(osc_run_in_off, 32'h0);
        off_mode <= 1'h0;
        wb(1'h0, 4'h0, 8'h00, q, e);
        chk(q, 32'hFC);
        chk(mode_report, 32'h3);
        chk(ctrl.prescale, 32'h1);
        wb(1'h0, 4'h8, 8'h00, q, e);
        chk(q, 32'hE2);
        $display("Test mode_and_once done");
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            exp_q.push_back({v[7], 3'(i), v[3], 3'(7 - i)});
            wb(1'h1, 4'h4, 8'(exp_q[$]), q, e);
            tick(8);
            chk(ctrl.mult_factor, 4 + 2 * i);
            chk(ctrl.div_factor, 1 << (7 - i));
            wb(1'h0, 4'h4, 8'h00, q, e);
            chk(q, exp_q.pop_front());
        end
        $display("Test factors done");
        wb(1'h1, 4'h4, 8'h08, q, e);
        lock_loss_in <= 1'h1;
        tick(4);
        lock_loss_in <= 1'h0;
        tick(4);
        chk({irq_request, reset_request, lock_loss_sticky}, 32'h5);
        wb(1'h1, 4'h8, 8'h10, q, e);
        tick(2);
        chk({irq_request, reset_request, lock_loss_sticky}, 32'h0);
        clock_loss_in <= 1'h1;
        tick(4);
        chk({irq_request, reset_request}, 32'h1);
        wb(1'h1, 4'h0, 8'hFE, q, e);
        tick(2);
        chk({irq_request, reset_request, ctrl.loss_detect_on}, 32'h0);
        clock_loss_in <= 1'h0;
        wb(1'h1, 4'h4, 8'h80, q, e);
        lock_loss_in <= 1'h1;
        tick(4);
        chk({irq_request, reset_request}, 32'h1);
        lock_loss_in <= 1'h0;
        $display("Test requests done");
        reset <= 1'h1;
        tick(3);
        reset <= 1'h0;
        wb(1'h0, 4'h0, 8'h00, q, e);
        chk(q, 32'h0);
        wb(1'h1, 4'h0, 8'h08, q, e);
        tick(8);
        wb(1'h1, 4'h0, 8'h18, q, e);
        tick(8);
        chk(mode_report, 32'h1);
        wb(1'h0, 4'hC, 8'h00, q, e);
        chk(e, 32'h1);
        $display("Test second_reset done");
        reset <= 1'h1;
        tick(3);
        reset <= 1'h0;
        wb(1'h1, 4'h0, 8'h34, q, e);
        off_mode <= 1'h1;
        tick(8);
        chk(osc_run_in_off, 32'h1);
        chk({ctrl.gain, ctrl.band, ctrl.ref_crystal, ctrl.prescale}, 32'hC0);
        chk(mode_report, 32'h2);
        wb(1'h1, 4'h0, 8'h30, q, e);
        tick(1);
        chk(osc_run_in_off, 32'h0);
        osc_enable_in <= 1'h1;
        tick(1);
        chk(osc_run_in_off, 32'h1);
        off_mode <= 1'h0;
        osc_enable_in <= 1'h0;
        tick(1);
        chk(osc_run_in_off, 32'h0);
        $display("Test osc_in_off done");
        end_of_test();
    end
endmodule
`default_nettype wire
